// ===== inc/sew_pkg.sv
// constants and types for the serial eeprom sequencer
package sew_pkg;
  // address layout
  localparam int unsigned ADDR_FIELD_W = 16;
  localparam int unsigned ADDR_W_DEF   = 15;
  localparam int unsigned PAGE_W       = 6;
  localparam int unsigned PAGE_BYTES   = 64;
  localparam int unsigned BP_W         = 2;
  localparam int unsigned BYTE_W       = 8;
  // command codes, bit 3 masked off before compare
  localparam logic [7:0] OPC_MASK          = 8'hF7;
  localparam logic [7:0] OPC_HI_MASK       = 8'hF0;
  localparam logic [7:0] write_enable_cmd  = 8'h06;
  localparam logic [7:0] write_disable_cmd = 8'h04;
  localparam logic [7:0] status_read_cmd   = 8'h05;
  localparam logic [7:0] mem_read_cmd      = 8'h03;
  localparam logic [7:0] mem_write_cmd     = 8'h02;
  // status byte
  localparam logic [7:0]  STATUS_BUSY  = 8'hFF;
  localparam logic [7:0]  STATUS_IDLE  = 8'h00;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_WEL_BIT   = 1;
  localparam int unsigned ST_BP_LSB    = 2;
  // protection levels
  localparam logic [1:0] BP_NONE    = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF    = 2'h2;
  localparam logic [1:0] BP_ALL     = 2'h3;
  // programming time
  localparam int unsigned T_WC_MS    = 5;
  localparam int unsigned CLK_KHZ    = 250000;
  localparam int unsigned WC_CYCLES  = T_WC_MS * CLK_KHZ;
  // reset values
  localparam int unsigned SYNC_W     = 5;
  localparam logic [4:0]  SYNC_RST   = 5'h10;
  localparam logic [2:0]  BIT_CNT_RST = 3'h0;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  // sequencer states, gray along opcode, address, read data
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPC    = 3'b001,
    ST_ADDR_H = 3'b011,
    ST_ADDR_L = 3'b010,
    ST_RD     = 3'b110,
    ST_WR     = 3'b111,
    ST_STAT   = 3'b101,
    ST_IGN    = 3'b100
  } sew_state_t;
  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_WRITE = 2'b01,
    PG_WAIT  = 2'b11
  } sew_pstate_t;
endpackage

// ===== inc/sew_mem_if.sv
// carrier between sequencer, programmer and array
`timescale 1ns/1ps
interface sew_mem_if #(parameter int unsigned ADDR_W = 15);
  logic              clr;
  logic              load;
  logic [5:0]        load_idx;
  logic [7:0]        load_data;
  logic              start;
  logic [ADDR_W-7:0] page;
  logic              busy;
  logic              done;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  modport core (output clr, load, load_idx, load_data, start, page, rd_addr,
                input  busy, done, rd_data);
  modport prog (input  clr, load, load_idx, load_data, start, page,
                output busy, done, wr_en, wr_addr, wr_data);
  modport mem  (input  rd_addr, wr_en, wr_addr, wr_data,
                output rd_data);
endinterface

// ===== design/sew_array.sv
// byte array with asynchronous read and clocked write
`timescale 1ns/1ps
module sew_array #(
  parameter int unsigned ADDR_W = sew_pkg::ADDR_W_DEF
) (
  // clock
  input wire logic clk_in,
  // access
  sew_mem_if.mem   mif
);
  import sew_pkg::*;

  logic [7:0] cells [2**ADDR_W];

  always_ff @(posedge clk_in) begin
    if (mif.wr_en) begin
      cells[mif.wr_addr] <= mif.wr_data;
    end
  end

  assign mif.rd_data = cells[mif.rd_addr];
endmodule

// ===== design/sew_prog.sv
// page buffer and self-timed programming cycle
`timescale 1ns/1ps
module sew_prog #(
  parameter int unsigned ADDR_W    = sew_pkg::ADDR_W_DEF,
  parameter int unsigned WC_CYCLES = sew_pkg::WC_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control and array write
  sew_mem_if.prog  mif
);
  import sew_pkg::*;

  localparam int unsigned CNT_W = $clog2(WC_CYCLES + 1);
  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WC_CYCLES - PAGE_BYTES - 1);
  localparam logic [5:0] IDX_LAST = 6'h3F;

  logic [7:0]      page_buf [PAGE_BYTES];
  logic [63:0]     loaded;
  sew_pstate_t     pstate;
  logic [5:0]      idx;
  logic [CNT_W-1:0] wait_cnt;
  logic            done;

  always_ff @(posedge clk_in) begin
    if (mif.load) begin
      page_buf[mif.load_idx] <= mif.load_data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      loaded <= 64'h0;
    end else if (mif.clr) begin
      loaded <= 64'h0;
    end else if (mif.load) begin
      loaded[mif.load_idx] <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pstate   <= PG_IDLE;
      idx      <= 6'h0;
      wait_cnt <= '0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (pstate)
        PG_IDLE: begin
          idx <= 6'h0;
          if (mif.start) begin
            pstate <= PG_WRITE;
          end
        end
        PG_WRITE: begin
          idx <= idx + 6'h1;
          wait_cnt <= '0;
          if (idx == IDX_LAST) begin
            pstate <= PG_WAIT;
          end
        end
        PG_WAIT: begin
          wait_cnt <= wait_cnt + CNT_W'(1);
          if (wait_cnt == WAIT_LAST) begin
            pstate <= PG_IDLE;
            done   <= 1'b1;
          end
        end
        default: pstate <= PG_IDLE;
      endcase
    end
  end

  assign mif.wr_en   = (pstate == PG_WRITE) && loaded[idx];
  assign mif.wr_addr = {mif.page, idx};
  assign mif.wr_data = page_buf[idx];
  assign mif.busy    = (pstate != PG_IDLE);
  assign mif.done    = done;
endmodule

// ===== design/sew_top.sv
// serial eeprom read and write sequencer, link side and core side
//
// Functional notes
// - read: select low, read opcode, then sixteen address bits, in that order.
// - after read opcode and address, further serial input is disregarded.
// - addressed byte shifts out on serial output, bit 7 first.
// - with select still low, address increments and next bytes follow.
// - read address past the top wraps to zero.
// - programming needs the write-enable latch set by an earlier command.
// - locations inside the protected range are never programmed.
// - during programming only the status read command is obeyed.
// - write: opcode, sixteen address bits, then one or more data bytes.
// - programming starts only when select returns high.
// - status bit 0 is one while programming, zero when done.
// - page writes up to 64 bytes; low six address bits increment.
// - beyond 64 bytes the page address wraps and bytes are replaced.
// - end of programming clears the write-enable latch.
// - write without the latch set is discarded; standby on select high.
// - after an ignored write only a new select fall restarts the link.
// - opcodes are eight bits with bit 3 ignored.
// - bytes travel most significant bit first; select fall starts each frame.
// - write-enable latch is clear after reset.
`timescale 1ns/1ps
module sew_top #(
  parameter int unsigned ADDR_W    = sew_pkg::ADDR_W_DEF,
  parameter int unsigned WC_CYCLES = sew_pkg::WC_CYCLES
) (
  // system clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // serial link
  input  wire logic                    sck_in,
  input  wire logic                    cs_n_in,
  input  wire logic                    si_in,
  output logic                         so_out,
  output logic                         so_oe_out,
  // protection level
  input  wire logic [sew_pkg::BP_W-1:0] block_protect_in,
  // state
  output logic                         busy_out,
  output logic                         write_enable_out
);
  import sew_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  sew_mem_if #(.ADDR_W(ADDR_W)) mif ();

  logic              link_rst_n;
  logic [2:0]        bit_cnt;
  logic [6:0]        rx_shift;
  logic [7:0]        rx_byte;
  logic              start_tgl;
  logic              done_tgl;
  logic [7:0]        tx_shift;
  logic              tx_drive;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic              cs_prev;
  logic              start_prev;
  logic              done_prev;
  logic              cs_sync;
  logic              cs_rise;
  logic              start_ev;
  logic              done_ev;
  logic [1:0]        bp_sync;

  sew_state_t        state;
  sew_state_t        next_state;
  logic [7:0]        opc;
  logic              is_write;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        tx_byte;
  logic              tx_en;
  logic              wel;
  logic              mid_byte;
  logic              wr_any;
  logic              prot_hit;
  logic [7:0]        status_now;
  logic              start_prog;

  //////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the serial clock

  // link logic held in reset while deselected
  assign link_rst_n = rst_n_in & ~cs_n_in;

  always_ff @(posedge sck_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt  <= BIT_CNT_RST;
      rx_shift <= 7'h0;
    end else begin
      bit_cnt  <= bit_cnt + 3'h1;
      rx_shift <= {rx_shift[5:0], si_in};
    end
  end

  // byte word and events survive deselect
  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_byte   <= 8'h00;
      start_tgl <= 1'b0;
      done_tgl  <= 1'b0;
    end else begin
      if (bit_cnt == BIT_CNT_RST) begin
        start_tgl <= ~start_tgl;
      end
      if (bit_cnt == BIT_LAST) begin
        rx_byte  <= {rx_shift, si_in};
        done_tgl <= ~done_tgl;
      end
    end
  end

  // output shifter loads on the falling edge after a whole byte
  always_ff @(negedge sck_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_shift <= 8'h00;
      tx_drive <= 1'b0;
    end else if (bit_cnt == BIT_CNT_RST) begin
      tx_shift <= tx_byte;
      tx_drive <= tx_en;
    end else begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  assign so_out    = tx_shift[7];
  assign so_oe_out = tx_drive & ~cs_n_in;

  //////////////////////////////////////////////////////////////////////////////
  // crossing into the core clock

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_meta <= SYNC_RST;
      sync_q    <= SYNC_RST;
    end else begin
      sync_meta <= {cs_n_in, start_tgl, done_tgl, block_protect_in};
      sync_q    <= sync_meta;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_prev    <= 1'b1;
      start_prev <= 1'b0;
      done_prev  <= 1'b0;
    end else begin
      cs_prev    <= sync_q[4];
      start_prev <= sync_q[3];
      done_prev  <= sync_q[2];
    end
  end

  assign cs_sync  = sync_q[4];
  assign cs_rise  = sync_q[4] & ~cs_prev;
  assign start_ev = sync_q[3] ^ start_prev;
  assign done_ev  = sync_q[2] ^ done_prev;
  assign bp_sync  = sync_q[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  assign opc = rx_byte & OPC_MASK;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (!cs_sync) begin
          next_state = ST_OPC;
        end
      end
      ST_OPC: begin
        if (done_ev) begin
          if (mif.busy) begin
            next_state = (opc == status_read_cmd) ? ST_STAT : ST_IGN;
          end else if (opc == status_read_cmd) begin
            next_state = ST_STAT;
          end else if (opc == mem_read_cmd) begin
            next_state = ST_ADDR_H;
          end else if (opc == mem_write_cmd) begin
            next_state = wel ? ST_ADDR_H : ST_IGN;
          end else begin
            next_state = ST_IGN;
          end
        end
      end
      ST_ADDR_H: begin
        if (done_ev) begin
          next_state = ST_ADDR_L;
        end
      end
      ST_ADDR_L: begin
        if (done_ev) begin
          next_state = is_write ? ST_WR : ST_RD;
        end
      end
      ST_RD:   next_state = ST_RD;
      ST_WR:   next_state = ST_WR;
      ST_STAT: next_state = ST_STAT;
      ST_IGN:  next_state = ST_IGN;
    endcase
    if (cs_sync) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      is_write <= 1'b0;
    end else if (state == ST_OPC && done_ev) begin
      is_write <= (opc == mem_write_cmd);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address counter

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr <= '0;
    end else if (state == ST_ADDR_H && done_ev) begin
      addr[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
    end else if (state == ST_ADDR_L && done_ev) begin
      addr[7:0] <= rx_byte;
    end else if (state == ST_RD && start_ev) begin
      addr <= addr + ADDR_W'(1);
    end else if (state == ST_WR && done_ev) begin
      addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 6'h1;
    end
  end

  // look one byte ahead so the shifter always finds data ready
  assign mif.rd_addr = (state == ST_ADDR_L) ? {addr[ADDR_W-1:8], rx_byte} : addr + ADDR_W'(1);

  //////////////////////////////////////////////////////////////////////////////
  // status and transmit word

  always_comb begin
    status_now = STATUS_IDLE;
    if (mif.busy) begin
      status_now = STATUS_BUSY;
    end else begin
      status_now[ST_BUSY_BIT]             = 1'b0;
      status_now[ST_WEL_BIT]              = wel;
      status_now[ST_BP_LSB+1:ST_BP_LSB]   = bp_sync;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_byte <= 8'h00;
      tx_en   <= 1'b0;
    end else if (cs_sync) begin
      tx_en <= 1'b0;
    end else if (state == ST_OPC && done_ev && next_state == ST_STAT) begin
      tx_byte <= status_now;
      tx_en   <= 1'b1;
    end else if (state == ST_STAT && start_ev) begin
      tx_byte <= status_now;
    end else if (state == ST_ADDR_L && done_ev && !is_write) begin
      tx_byte <= mif.rd_data;
      tx_en   <= 1'b1;
    end else if (state == ST_RD && start_ev) begin
      tx_byte <= mif.rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write-enable latch

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wel <= 1'b0;
    end else if (mif.done) begin
      wel <= 1'b0;
    end else if (state == ST_OPC && done_ev && !mif.busy) begin
      if (opc == write_enable_cmd) begin
        wel <= 1'b1;
      end else if (opc == write_disable_cmd) begin
        wel <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // page loading and programming start

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mid_byte <= 1'b0;
    end else if (start_ev) begin
      mid_byte <= 1'b1;
    end else if (done_ev) begin
      mid_byte <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_any <= 1'b0;
    end else if (state == ST_ADDR_L && done_ev) begin
      wr_any <= 1'b0;
    end else if (state == ST_WR && done_ev) begin
      wr_any <= 1'b1;
    end
  end

  always_comb begin
    prot_hit = 1'b0;
    unique case (bp_sync)
      BP_NONE:    prot_hit = 1'b0;
      BP_QUARTER: prot_hit = (addr[ADDR_W-1:ADDR_W-2] == 2'h3);
      BP_HALF:    prot_hit = addr[ADDR_W-1];
      BP_ALL:     prot_hit = 1'b1;
    endcase
  end

  // only a whole final byte, the latch and an open range may start programming
  assign start_prog = cs_rise && state == ST_WR && wr_any && !mid_byte
                      && wel && !prot_hit;

  assign mif.clr       = (state == ST_ADDR_L) && done_ev && is_write;
  assign mif.load      = (state == ST_WR) && done_ev;
  assign mif.load_idx  = addr[PAGE_W-1:0];
  assign mif.load_data = rx_byte;
  assign mif.start     = start_prog;
  assign mif.page      = addr[ADDR_W-1:PAGE_W];

  //////////////////////////////////////////////////////////////////////////////
  // array and programmer

  sew_prog #(
    .ADDR_W    (ADDR_W),
    .WC_CYCLES (WC_CYCLES)
  ) u_prog (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .mif      (mif.prog)
  );

  sew_array #(
    .ADDR_W (ADDR_W)
  ) u_array (
    .clk_in (clk_in),
    .mif    (mif.mem)
  );

  assign busy_out         = mif.busy;
  assign write_enable_out = wel;
endmodule

// ===== bench/sew_top_chk.sv
// assertions on the sequencer top ports
`timescale 1ns/1ps
module sew_top_chk
  import sew_pkg::*;
#(
  parameter int unsigned ADDR_W    = ADDR_W_DEF,
  parameter int unsigned WC_CYCLES = sew_pkg::WC_CYCLES
) (
  // watched ports
  input wire logic            clk_in,
  input wire logic            rst_n_in,
  input wire logic            sck_in,
  input wire logic            cs_n_in,
  input wire logic            si_in,
  input wire logic            so_out,
  input wire logic            so_oe_out,
  input wire logic [BP_W-1:0] block_protect_in,
  input wire logic            busy_out,
  input wire logic            write_enable_out
);
  localparam int unsigned LEN_LO = WC_CYCLES - 2;
  localparam int unsigned LEN_HI = WC_CYCLES + 2;
  int unsigned busy_len;
  logic [5:0]  edge_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // helper counters
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_len <= '0;
    end else if (busy_out) begin
      busy_len <= busy_len + 1;
    end else begin
      busy_len <= '0;
    end
  end
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      edge_cnt <= 6'h00;
    end else if (edge_cnt != 6'h3F) begin
      edge_cnt <= edge_cnt + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // properties
  sequence s_prog_start;
    $rose(busy_out);
  endsequence
  sequence s_prog_end;
    $fell(busy_out);
  endsequence
  a_oe_off_at_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(cs_n_in) |-> !so_oe_out) else $error("output enabled at frame start");
  a_busy_full_length: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_prog_end |-> busy_len >= LEN_LO && busy_len <= LEN_HI) else $error("busy length wrong");
  a_latch_clear_end: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_prog_end |=> !write_enable_out) else $error("latch set after programming");
  a_prog_needs_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_prog_start |-> write_enable_out) else $error("programming without latch");
  a_prog_after_deselect: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_prog_start |-> cs_n_in && $past(cs_n_in)) else $error("programming while selected");
  a_prot_all_refused: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_prog_start |-> block_protect_in != BP_ALL) else $error("programming while all protected");
  a_no_latch_busy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    busy_out |=> !$rose(write_enable_out)) else $error("latch set while busy");
  a_reset_clean_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> !write_enable_out && !busy_out) else $error("state not clear after reset");
  a_reply_after_cmd: assert property (@(posedge sck_in) disable iff (cs_n_in || !rst_n_in)
    so_oe_out |-> edge_cnt >= 6'h08) else $error("reply before command byte");
endmodule
bind sew_top sew_top_chk #(.ADDR_W(ADDR_W), .WC_CYCLES(WC_CYCLES)) u_chk (
  .clk_in, .rst_n_in, .sck_in, .cs_n_in, .si_in, .so_out, .so_oe_out,
  .block_protect_in, .busy_out, .write_enable_out
);

// ===== bench/sew_host.sv
// host master model driving the serial link
`timescale 1ns/1ps
module sew_host (
  // link
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  logic saw_oe;
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
    saw_oe   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // frame opens with a fresh select fall, clock idle low
  task automatic sel();
    #5.3;
    cs_n_out = 1'b0;
    saw_oe   = 1'b0;
    #24;
  endtask
  // msb first, reply sampled on rising edge
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      si_out = tx[i];
      #24;
      sck_out = 1'b1;
      rx[i]   = so_in;
      saw_oe  = saw_oe | so_oe_in;
      #24;
      sck_out = 1'b0;
    end
  endtask
  // select rises in clock low time right after the last bit
  task automatic desel();
    #5;
    cs_n_out = 1'b1;
    si_out   = ~si_out;
    #200;
  endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the serial eeprom sequencer
`timescale 1ns/1ps
module testbench;
  import sew_pkg::*;
  localparam int unsigned WC = 1000;
  logic            clk_in;
  logic            rst_n_in;
  logic            sck;
  logic            cs_n;
  logic            si;
  logic            so;
  logic            so_oe;
  logic            busy;
  logic            wel;
  logic [BP_W-1:0] bp;
  int              fails;
  int              n_tests;
  int              seed;
  logic [7:0]      ref_mem [logic [14:0]];
  logic [7:0]      rx;
  logic [7:0]      st;
  sew_top #(.ADDR_W(15), .WC_CYCLES(WC)) u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .so_out(so), .so_oe_out(so_oe), .block_protect_in(bp), .busy_out(busy), .write_enable_out(wel));
  sew_host u_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));
  always #2 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  // checking and ending
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp || $isunknown(exp)) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic prot(input logic [14:0] a, input logic [1:0] lvl);
    case (lvl)
      BP_QUARTER: return a >= 15'h6000;
      BP_HALF:    return a >= 15'h4000;
      BP_ALL:     return 1'b1;
      default:    return 1'b0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // link operations
  task automatic status(output logic [7:0] s);
    u_host.sel();
    u_host.xfer(status_read_cmd, 8, s);
    u_host.xfer(8'h00, 8, s);
    u_host.desel();
  endtask
  task automatic wr(input logic [15:0] a, input int n, input int tail, input logic en);
    logic [7:0] d;
    logic [7:0] idle;
    logic [5:0] idx;
    logic       go;
    go   = en && n > 0 && tail == 0 && !prot({a[14:6], 6'h00}, bp);
    idle = {4'h0, bp, en && !go, 1'b0};
    u_host.sel();
    u_host.xfer(en ? write_enable_cmd : write_disable_cmd, 8, rx);
    u_host.desel();
    chk("latch", {7'h00, en}, {7'h00, wel});
    u_host.sel();
    u_host.xfer(mem_write_cmd, 8, rx);
    u_host.xfer(a[15:8], 8, rx);
    u_host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      d   = 8'($random(seed));
      idx = a[5:0] + 6'(i);
      if (go) ref_mem[{a[14:6], idx}] = d;
      u_host.xfer(d, 8, rx);
    end
    if (tail > 0) u_host.xfer(8'hA5, tail, rx);
    u_host.desel();
    status(st);
    chk("first status", go ? 8'hFF : idle, st);
    if (go) begin
      chk("busy", 8'h01, {7'h00, busy});
      u_host.sel();
      for (int i = 0; i < 4; i++) u_host.xfer(mem_read_cmd, 8, rx);
      u_host.desel();
      chk("ignored read", 8'h00, {7'h00, u_host.saw_oe});
      for (int k = 0; k < 8 && st !== idle; k++) status(st);
    end
    chk("idle status", idle, st);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    u_host.sel();
    u_host.xfer(mem_read_cmd | {4'h0, 1'($random(seed)), 3'h0}, 8, rx);
    u_host.xfer(a[15:8], 8, rx);
    u_host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'($random(seed)), 8, rx);
      chk("read data", ref_mem[15'(a + 16'(i))], rx);
    end
    u_host.desel();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    clk_in   = 1'b0;
    rst_n_in = 1'b0;
    bp       = BP_NONE;
    fails    = 0;
    n_tests  = 0;
    seed     = 63;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("latch after reset", 8'h00, {7'h00, wel});
    status(st);
    chk("status after reset", 8'h00, st);
    wr(16'h0010, 3, 0, 1'b0);
    wr({10'h200, 6'($random(seed))}, 66, 0, 1'b1);
    wr({10'h1FF, 6'($random(seed))}, 64, 0, 1'b1);
    rd(16'h7FFE, 4);
    rd({10'h1FF, 6'($random(seed))}, 20);
    wr(16'h0044, 4, 0, 1'b1);
    wr(16'h0045, 2, 4, 1'b1);
    rd(16'h0044, 4);
    for (int lvl = 0; lvl < 4; lvl++) begin
      @(posedge clk_in);
      bp <= 2'(lvl);
      repeat (4) @(posedge clk_in);
      wr(16'h5040, 2, 0, 1'b1);
      rd(16'h5040, 2);
    end
    report_and_stop();
  end
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
endmodule
